/* File: dv/ctl_chan_cfg_bench.sv */
// Self-checking bench for the control channel configuration block
`timescale 1ns/10ps
`default_nettype none
module ctl_chan_cfg_bench;
  import ctl_chan_cfg_pkg::*;
  localparam int FAST = 40;  // Short watchdog spans keep the run brief
  localparam int SLOW = 60;
  localparam int HALF = 4;
  logic       mclk_i = 1'b0, rst_n_i = 1'b0, hang = 1'b0;
  logic       reg_wr_i = 1'b0, rmt_wr_i = 1'b0, rmt_slave_req_i = 1'b0;
  logic       seq_err_i = 1'b0, rx_lock_i = 1'b0, sda_low_req_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rmt_addr_i = 8'h00, rmt_wdata_i = 8'h00;
  logic [6:0] ser_id_i = 7'h00, txn_addr_i = 7'h00, alias_i = 7'h00;
  logic [7:0] reg_rdata_o;
  logic [6:0] ser_addr_o, fwd_addr_o, id;
  logic       rmt_wr_rejected_o, rmt_slave_fwd_o, ser_access_en_o, scl_i, sda_i;
  logic       scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, bus_free_o, bus_recovering_o;
  logic [7:0] m_ctl = 8'h00, m_ser = 8'h00, m_sl0 = 8'h00;  // Reference register copies
  logic       m_err = 1'b0;                                 // Reference error flag
  int         err_count = 0, check_count = 0, seed = 45521, k, clocks;
  logic [7:0] addrs[$] = '{8'h06, 8'h07, 8'h08, 8'h05, 8'h09};
  always #2.5 mclk_i = ~mclk_i;
  ctl_chan_cfg #(.WD_FAST_CYCLES(FAST), .WD_SLOW_CYCLES(SLOW), .RECOV_HALF_CYCLES(HALF)) dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .rmt_wr_i(rmt_wr_i),
    .rmt_addr_i(rmt_addr_i), .rmt_wdata_i(rmt_wdata_i), .rmt_wr_rejected_o(rmt_wr_rejected_o),
    .rmt_slave_req_i(rmt_slave_req_i), .rmt_slave_fwd_o(rmt_slave_fwd_o), .seq_err_i(seq_err_i),
    .rx_lock_i(rx_lock_i), .ser_id_i(ser_id_i), .ser_addr_o(ser_addr_o),
    .ser_access_en_o(ser_access_en_o), .txn_addr_i(txn_addr_i), .alias_match_address_0_i(alias_i),
    .fwd_addr_o(fwd_addr_o), .sda_low_req_i(sda_low_req_i), .scl_i(scl_i), .sda_i(sda_i),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .bus_free_o(bus_free_o), .bus_recovering_o(bus_recovering_o));
  i2c_far_side bus (.mclk_i(mclk_i), .hang_i(hang), .scl_oe_n_i(scl_oe_n_o),
    .sda_oe_n_i(sda_oe_n_o), .scl_o(scl_i), .sda_o(sda_i), .clocks_o(clocks));
  // Inputs always move one nanosecond after the edge
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] m_read(input logic [7:0] a);
    case (a)
      CTL_TWO_OFS:  return {m_err, m_ctl[6:0]};
      SER_ADDR_OFS: return m_ser;
      SLAVE0_OFS:   return m_sl0;
      default:      return 8'h00;
    endcase
  endfunction
  // Local write: one strobe cycle then one idle edge, so a following call never re-raises the strobe in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    tick();
    reg_wr_i = 1'b0;
    if (a == CTL_TWO_OFS) m_ctl = d & 8'h5f;
    if (a == SER_ADDR_OFS) m_ser = d;
    if (a == SLAVE0_OFS) m_sl0 = d;
    tick();
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr_i = a;
    tick();
    chk(reg_rdata_o, m_read(a), "read");
  endtask
  // Remote write: dropped with a one-cycle pulse while the block bit is set
  task automatic rmt(input logic [7:0] a, input logic [7:0] d);
    rmt_wr_i    = 1'b1;
    rmt_addr_i  = a;
    rmt_wdata_i = d;
    tick();
    rmt_wr_i = 1'b0;
    chk({7'h0, rmt_wr_rejected_o}, {7'h0, m_ctl[2]}, "reject pulse");
    tick();
    chk({7'h0, rmt_wr_rejected_o}, 8'h00, "reject end");
    if (!m_ctl[2] && a == SLAVE0_OFS) m_sl0 = d;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0:       return bus_free_o;
      1:       return bus_recovering_o;
      2:       return scl_oe_n_o;
      default: return sda_oe_n_o;
    endcase
  endfunction
  // Bounded wait for one output to reach a level; k ends at lim on a hang
  task automatic wait_sig(input int w, input logic v, input int lim);
    k = 0;
    do begin
      tick();
      k++;
    end while (pick(w) !== v && k < lim);
  endtask
  // Free-bus detection from a counter freshly cleared by the disable bit
  task automatic wd_free(input logic [7:0] ctl, input int t);
    wr(CTL_TWO_OFS, 8'h01);
    wr(CTL_TWO_OFS, ctl);
    wait_sig(0, 1'b1, t + 20);
    chk({7'h0, (k >= t - 1 && k <= t + 4)}, 8'h01, "free timeout");
  endtask
  task automatic give_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog on the whole run, far above the thousand or so cycles needed
  initial begin
    #200000;
    err_count++;
    $display("BAD %0t run hung", $time);
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    foreach (addrs[i]) rd(addrs[i]);
    wr(8'h05, 8'hff);
    rd(8'h05);
    wr(CTL_TWO_OFS, 8'hff);
    rd(CTL_TWO_OFS);
    wr(CTL_TWO_OFS, 8'h01);
    // Sticky error flag, then cleared by the clear control
    seq_err_i = 1'b1;
    tick();
    seq_err_i = 1'b0;
    m_err = 1'b1;
    repeat (5) tick();
    rd(CTL_TWO_OFS);
    wr(CTL_TWO_OFS, 8'h41);
    tick();
    m_err = 1'b0;
    wr(CTL_TWO_OFS, 8'h01);
    rd(CTL_TWO_OFS);
    // Remote writes pass, then are blocked while slave access still passes
    rmt(SLAVE0_OFS, 8'($random(seed)));
    rd(SLAVE0_OFS);
    wr(CTL_TWO_OFS, 8'h05);
    rmt(SLAVE0_OFS, 8'($random(seed)));
    rd(SLAVE0_OFS);
    rmt_slave_req_i = 1'b1;
    tick();
    chk({7'h0, rmt_slave_fwd_o}, 8'h01, "slave forward");
    rmt_slave_req_i = 1'b0;
    wr(CTL_TWO_OFS, 8'h01);
    // Collision: local write wins and the remote one is reported dropped
    rmt_wr_i    = 1'b1;
    rmt_addr_i  = SLAVE0_OFS;
    rmt_wdata_i = 8'h3c;
    reg_wr_i    = 1'b1;
    reg_addr_i  = SLAVE0_OFS;
    reg_wdata_i = 8'hc3;
    tick();
    rmt_wr_i = 1'b0;
    reg_wr_i = 1'b0;
    m_sl0    = 8'hc3;
    chk({7'h0, rmt_wr_rejected_o}, 8'h01, "collision reject");
    rd(SLAVE0_OFS);
    // Serializer address loads on lock unless held
    id = 7'($random(seed)) | 7'h01;
    ser_id_i  = id;
    rx_lock_i = 1'b1;
    repeat (3) tick();
    m_ser = {id, 1'b0};
    chk({1'b0, ser_addr_o}, {1'b0, id}, "autoload");
    rd(SER_ADDR_OFS);
    chk({7'h0, ser_access_en_o}, 8'h01, "access on");
    wr(SER_ADDR_OFS, {~id, 1'b1});
    rx_lock_i = 1'b0;
    tick();
    ser_id_i  = 7'h2a;
    rx_lock_i = 1'b1;
    repeat (3) tick();
    rd(SER_ADDR_OFS);
    wr(SER_ADDR_OFS, 8'h00);
    repeat (3) tick();
    chk({7'h0, ser_access_en_o}, 8'h00, "access off");
    rx_lock_i = 1'b0;
    // Alias remap, matching on every other pass
    for (int i = 0; i < 8; i++) begin
      wr(SLAVE0_OFS, 8'($random(seed)));
      alias_i    = 7'($random(seed));
      txn_addr_i = i[0] ? alias_i : 7'($random(seed));
      tick();
      chk({1'b0, fwd_addr_o}, {1'b0, (txn_addr_i == alias_i) ? m_sl0[7:1] : txn_addr_i}, "remap");
    end
    // SDA output delay for every code, watchdog off
    for (int c = 0; c < 4; c++) begin
      wr(CTL_TWO_OFS, 8'h01 | 8'(c << 3));
      sda_low_req_i = 1'b1;
      wait_sig(3, 1'b0, 200);
      chk(8'(k), 8'(SDA_BASE_CYC + c * SDA_STEP_CYC + 1), "sda delay");
      sda_low_req_i = 1'b0;
      repeat (100) tick();
    end
    wd_free(8'h02, FAST);
    wd_free(8'h00, SLOW);
    wr(CTL_TWO_OFS, 8'h01);
    wait_sig(0, 1'b1, 200);
    chk(8'(k), 8'd200, "disabled");
    // Hung bus: nine SCL clocks free the stuck slave, then bus is free
    hang = 1'b1;
    tick();
    hang = 1'b0;
    wr(CTL_TWO_OFS, 8'h02);
    wait_sig(1, 1'b1, FAST + 20);
    chk({7'h0, (k >= FAST - 1 && k <= FAST + 4)}, 8'h01, "recover start");
    // SCL is pulled at the same edge that starts recovery, so the low half is timed from here
    chk({7'h0, scl_oe_n_o}, 8'h00, "scl pulled");
    wait_sig(2, 1'b1, 20);
    chk(8'(k), 8'(HALF), "scl low time");
    wait_sig(1, 1'b0, 200);
    chk(8'(clocks), 8'd9, "nine clocks");
    wait_sig(0, 1'b1, 2 * FAST);
    chk({7'h0, bus_free_o}, 8'h01, "free after");
    chk({6'h00, scl_o, sda_o}, 8'h00, "open drain data");
    give_verdict();
  end
endmodule // ctl_chan_cfg_bench
`default_nettype wire

/* File: dv/i2c_far_side.sv */
// Far-side I2C bus model: pull-ups, open-drain merge and a slave that can hang SDA
`timescale 1ns/10ps
`default_nettype none
module i2c_far_side (
  input  wire logic mclk_i,
  input  wire logic hang_i,      // Slave gets stuck mid-byte
  input  wire logic scl_oe_n_i,  // Device pulls SCL low when 0
  input  wire logic sda_oe_n_i,  // Device pulls SDA low when 0
  output logic      scl_o,       // Resolved SCL level
  output logic      sda_o,       // Resolved SDA level
  output int        clocks_o     // SCL rises seen while stuck
);
  logic stuck_q = 1'b0;          // Slave holds SDA low
  logic scl_q   = 1'b1;          // Last SCL level, for edge finding
  initial clocks_o = 0;
  // Pull-ups win unless someone pulls low, so no line is left floating
  assign scl_o = scl_oe_n_i;
  assign sda_o = sda_oe_n_i & ~stuck_q;
  // A stuck slave lets go only after nine SCL rises, as a real one would
  always @(posedge mclk_i) begin
    scl_q <= scl_o;
    if (hang_i) begin
      stuck_q  <= 1'b1;
      clocks_o <= 0;
    end else if (stuck_q && scl_o && !scl_q) begin
      clocks_o <= clocks_o + 1;
      if (clocks_o == 8) begin
        stuck_q <= 1'b0;
      end
    end
  end
endmodule // i2c_far_side
`default_nettype wire

/* File: logic/ctl_chan_cfg.sv */
// Control channel I2C configuration, supervision and alias remap logic
//
// Overview of operation
// [RL1] Bit 7 flags forward sequence error
// [RL2] Writing bit 6 clears error flag
// [RL3] Bits 4-3 set SDA delay 250-400ns
// [RL4] Bit 2 blocks remote local-register writes
// [RL5] Remote slave access unaffected by write block
// [RL6] Watchdog timeout 50us fast, 1s slow
// [RL7] Bit 0 disables bus watchdog
// [RL8] Idle high SDA at timeout: bus free
// [RL9] Idle low SDA at timeout: nine SCL clocks
// [RL10] Zero serializer address disables its access
// [RL11] Serializer address loaded on receive lock
// [RL12] Hold bit stops serializer address autoload
// [RL13] Software writing address should set hold
// [RL14] Alias 0 remapped to physical address
// [RL15] Error flag sticky until cleared, resets zero
`timescale 1ns/10ps
`default_nettype none
module ctl_chan_cfg
  import ctl_chan_cfg_pkg::*;
#(
  parameter int unsigned WD_FAST_CYCLES = WD_FAST_CYC,    // Shorten in simulation
  parameter int unsigned WD_SLOW_CYCLES = WD_SLOW_CYC,    // Shorten in simulation
  parameter int unsigned RECOV_HALF_CYCLES = RECOV_HALF_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Local register port
  input  wire logic       reg_wr_i,           // Local write strobe
  input  wire logic [7:0] reg_addr_i,         // Register offset
  input  wire logic [7:0] reg_wdata_i,        // Write data
  output logic      [7:0] reg_rdata_o,        // Read data, one cycle later
  // Register writes arriving over the control channel
  input  wire logic       rmt_wr_i,           // Remote write strobe
  input  wire logic [7:0] rmt_addr_i,         // Remote write offset
  input  wire logic [7:0] rmt_wdata_i,        // Remote write data
  output logic            rmt_wr_rejected_o,  // Pulse: remote write dropped
  // Remote access to slaves behind this device
  input  wire logic       rmt_slave_req_i,    // Remote slave access request
  output logic            rmt_slave_fwd_o,    // Request passed to local bus
  // Forward channel status
  input  wire logic       seq_err_i,          // Pulse: sequence error seen
  input  wire logic       rx_lock_i,          // Receive lock level
  input  wire logic [6:0] ser_id_i,           // Address supplied by serializer
  output logic      [6:0] ser_addr_o,         // Current serializer address
  output logic            ser_access_en_o,    // Serializer reachable
  // Local transaction address remap
  input  wire logic [6:0] txn_addr_i,         // Address of local transaction
  input  wire logic [6:0] alias_match_address_0_i,
  output logic      [6:0] fwd_addr_o,         // Address sent to serializer
  // I2C pins, open drain
  input  wire logic       sda_low_req_i,      // Engine wants SDA low
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oe_n_o,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic            bus_free_o,         // Pulse: watchdog saw free bus
  output logic            bus_recovering_o    // Watchdog clocking SCL
);
  // Control register fields
  logic        seq_err_q;      // Sticky sequence error
  logic        seq_clr_q;      // Clear control, held while one
  logic [1:0]  sda_dly_q;      // SDA delay code
  logic        loc_wr_dis_q;   // Block remote local writes
  logic        wd_fast_q;      // bus_watchdog_fast
  logic        wd_dis_q;       // Watchdog disable
  logic [6:0]  ser_addr_q;     // remote_serializer_address
  logic        hold_q;         // hold_serializer_address
  logic [6:0]  slave0_q;       // remote_slave_physical_addr_0
  logic        slave0_rsv_q;   // Reserved read-write bit
  logic        lock_prev_q;    // For lock rising edge
  logic [SDA_MAX_CYC-1:0] sda_pipe_q; // SDA drive history
  // Write merge
  logic        wr;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        rmt_ok;
  logic        lock_rise;

  // Nominal SDA delay in clock cycles for a code
  function automatic logic [6:0] sda_delay(input logic [1:0] code);
    sda_delay = 7'(SDA_BASE_CYC + SDA_STEP_CYC * code);
  endfunction

  // Local writes win a collision; the remote one is then dropped too
  assign rmt_ok    = rmt_wr_i && !loc_wr_dis_q && !reg_wr_i; // [RL4]
  assign wr        = reg_wr_i || rmt_ok;
  assign wr_addr   = reg_wr_i ? reg_addr_i : rmt_addr_i;
  assign wr_data   = reg_wr_i ? reg_wdata_i : rmt_wdata_i;
  assign lock_rise = rx_lock_i && !lock_prev_q;

  // Control register configuration fields
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      seq_clr_q    <= CTL_TWO_RST[SEQ_CLR_BIT];
      sda_dly_q    <= CTL_TWO_RST[SDA_DLY_HI:SDA_DLY_LO];
      loc_wr_dis_q <= CTL_TWO_RST[LOC_WR_DIS_BIT];
      wd_fast_q    <= CTL_TWO_RST[WD_FAST_BIT];
      wd_dis_q     <= CTL_TWO_RST[WD_DIS_BIT];
    end else if (wr && wr_addr == CTL_TWO_OFS) begin
      seq_clr_q    <= wr_data[SEQ_CLR_BIT];
      sda_dly_q    <= wr_data[SDA_DLY_HI:SDA_DLY_LO];
      loc_wr_dis_q <= wr_data[LOC_WR_DIS_BIT];
      wd_fast_q    <= wr_data[WD_FAST_BIT];
      wd_dis_q     <= wr_data[WD_DIS_BIT];
    end
  end

  // Sticky sequence error; a new error wins over the clear
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      seq_err_q <= CTL_TWO_RST[SEQ_ERR_BIT]; // [RL15]
    end else if (seq_err_i) begin
      seq_err_q <= 1'b1; // [RL1]
    end else if (seq_clr_q) begin
      seq_err_q <= 1'b0; // [RL2]
    end
  end

  // Serializer address: software write, else autoload on lock unless held
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ser_addr_q  <= SER_ADDR_RST[ADDR_HI:ADDR_LO];
      hold_q      <= SER_ADDR_RST[HOLD_BIT];
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= rx_lock_i;
      if (wr && wr_addr == SER_ADDR_OFS) begin
        ser_addr_q <= wr_data[ADDR_HI:ADDR_LO];
        hold_q     <= wr_data[HOLD_BIT];
      end else if (lock_rise && !hold_q) begin // [RL12]
        ser_addr_q <= ser_id_i; // [RL11]
      end
    end
  end

  // Physical address for alias 0
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      slave0_q     <= SLAVE0_RST[ADDR_HI:ADDR_LO];
      slave0_rsv_q <= SLAVE0_RST[HOLD_BIT];
    end else if (wr && wr_addr == SLAVE0_OFS) begin
      slave0_q     <= wr_data[ADDR_HI:ADDR_LO];
      slave0_rsv_q <= wr_data[HOLD_BIT];
    end
  end

  // Read back; unmapped offsets and reserved bit 5 read zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      unique case (reg_addr_i)
        CTL_TWO_OFS:  reg_rdata_o <= {seq_err_q, seq_clr_q, 1'b0, sda_dly_q, loc_wr_dis_q, wd_fast_q, wd_dis_q};
        SER_ADDR_OFS: reg_rdata_o <= {ser_addr_q, hold_q};
        SLAVE0_OFS:   reg_rdata_o <= {slave0_q, slave0_rsv_q};
        default:      reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Remote path status, remap and serializer outputs
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rmt_wr_rejected_o <= 1'b0;
      rmt_slave_fwd_o   <= 1'b0;
      ser_addr_o        <= 7'h00;
      ser_access_en_o   <= 1'b0;
      fwd_addr_o        <= 7'h00;
    end else begin
      rmt_wr_rejected_o <= rmt_wr_i && !rmt_ok; // [RL4]
      // Slave traffic never sees the local write block
      rmt_slave_fwd_o   <= rmt_slave_req_i; // [RL5]
      ser_addr_o        <= ser_addr_q;
      ser_access_en_o   <= (ser_addr_q != 7'h00); // [RL10]
      fwd_addr_o        <= (txn_addr_i == alias_match_address_0_i) ? slave0_q : txn_addr_i; // [RL14]
    end
  end

  // SDA output delay line; a shift register trades flops for exact timing
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sda_pipe_q <= '0;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_pipe_q <= {sda_pipe_q[SDA_MAX_CYC-2:0], sda_low_req_i};
      sda_oe_n_o <= !sda_pipe_q[sda_delay(sda_dly_q) - 7'h01]; // [RL3]
    end
  end

  // Open-drain data lines are always zero
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  i2c_bus_watchdog #(
    .FAST_CYC (WD_FAST_CYCLES),
    .SLOW_CYC (WD_SLOW_CYCLES),
    .HALF_CYC (RECOV_HALF_CYCLES)
  ) u_watchdog (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .wd_disable_i (wd_dis_q),
    .wd_fast_i    (wd_fast_q),
    .scl_i        (scl_i),
    .sda_i        (sda_i),
    .bus_free_o   (bus_free_o),
    .recovering_o (bus_recovering_o),
    .scl_oe_n_o   (scl_oe_n_o)
  );

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  seq_err_set_a: assert property (seq_err_i |=> seq_err_q) // [RL1]
    else $error("Sequence error not flagged");
  seq_err_clr_a: assert property (seq_clr_q && !seq_err_i |=> !seq_err_q) // [RL2]
    else $error("Sequence error not cleared");
  seq_err_hold_a: assert property (seq_err_q && !seq_clr_q |=> seq_err_q) // [RL15]
    else $error("Sequence error dropped");
  sda_delay_a: assert property (sda_dly_q == 2'b00 && $stable(sda_dly_q) [*2] ##0 $rose(sda_pipe_q[49])
    |=> $fell(sda_oe_n_o)) // [RL3]
    else $error("SDA delay wrong");
  rmt_block_a: assert property (rmt_wr_i && loc_wr_dis_q && !reg_wr_i |=> rmt_wr_rejected_o && $stable(slave0_q)) // [RL4]
    else $error("Remote write passed while blocked");
  slave_pass_a: assert property (rmt_slave_req_i |=> rmt_slave_fwd_o) // [RL5]
    else $error("Remote slave access blocked");
  autoload_a: assert property (lock_rise && !hold_q && !wr |=> ser_addr_q == $past(ser_id_i)) // [RL11]
    else $error("Serializer address not loaded");
  hold_addr_a: assert property (lock_rise && hold_q && !wr |=> $stable(ser_addr_q)) // [RL12]
    else $error("Held address changed");
  ser_zero_a: assert property (ser_addr_q == 7'h00 |=> !ser_access_en_o) // [RL10]
    else $error("Zero address left access on");
  alias_remap_a: assert property (txn_addr_i == alias_match_address_0_i |=> fwd_addr_o == $past(slave0_q)) // [RL14]
    else $error("Alias not remapped");

  err_clear_c: cover property (seq_err_q ##1 !seq_err_q);
  rmt_block_c: cover property (rmt_wr_rejected_o);
  autoload_c: cover property (lock_rise && !hold_q);
endmodule // ctl_chan_cfg
`default_nettype wire

/* File: logic/ctl_chan_cfg_pkg.sv */
// Package of offsets, fields, resets and timing for the control channel configuration block
package ctl_chan_cfg_pkg;
  // Register offsets on the local register port
  localparam logic [7:0] CTL_TWO_OFS = 8'h06;
  localparam logic [7:0] SER_ADDR_OFS = 8'h07;
  localparam logic [7:0] SLAVE0_OFS = 8'h08;
  // Field positions of i2c_channel_control_two
  localparam int unsigned SEQ_ERR_BIT = 7;
  localparam int unsigned SEQ_CLR_BIT = 6;
  localparam int unsigned SDA_DLY_HI = 4;
  localparam int unsigned SDA_DLY_LO = 3;
  localparam int unsigned LOC_WR_DIS_BIT = 2;
  localparam int unsigned WD_FAST_BIT = 1;
  localparam int unsigned WD_DIS_BIT = 0;
  // Field positions of the address registers
  localparam int unsigned ADDR_HI = 7;
  localparam int unsigned ADDR_LO = 1;
  localparam int unsigned HOLD_BIT = 0;
  // Reset values
  localparam logic [7:0] CTL_TWO_RST = 8'h00;
  localparam logic [7:0] SER_ADDR_RST = 8'h00;
  localparam logic [7:0] SLAVE0_RST = 8'h00;
  // Clock and times
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SDA_BASE_NS = 250;
  localparam int unsigned SDA_STEP_NS = 50;
  localparam int unsigned SDA_BASE_CYC = SDA_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned SDA_STEP_CYC = SDA_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned SDA_MAX_CYC = SDA_BASE_CYC + 3 * SDA_STEP_CYC;
  localparam int unsigned WD_FAST_NS = 50000;
  localparam int unsigned WD_SLOW_NS = 1000000000;
  localparam int unsigned WD_FAST_CYC = WD_FAST_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_SLOW_CYC = WD_SLOW_NS / CLK_PERIOD_NS;
  localparam int unsigned RECOV_HALF_NS = 5000;
  localparam int unsigned RECOV_HALF_CYC = RECOV_HALF_NS / CLK_PERIOD_NS;
  localparam int unsigned RECOV_PULSES = 9;
  localparam int unsigned WD_CNT_W = 28;
endpackage

/* File: logic/i2c_bus_watchdog.sv */
// I2C bus watchdog: free-bus detection and nine-clock hung-bus recovery
`timescale 1ns/10ps
`default_nettype none
module i2c_bus_watchdog
  import ctl_chan_cfg_pkg::*;
#(
  parameter int unsigned FAST_CYC = WD_FAST_CYC,
  parameter int unsigned SLOW_CYC = WD_SLOW_CYC,
  parameter int unsigned HALF_CYC = RECOV_HALF_CYC
) (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic wd_disable_i,   // Watchdog off
  input  wire logic wd_fast_i,      // Short timeout
  input  wire logic scl_i,          // Sampled SCL level
  input  wire logic sda_i,          // Sampled SDA level
  output logic      bus_free_o,     // One-cycle pulse, bus seen free
  output logic      recovering_o,   // High while clocking SCL
  output logic      scl_oe_n_o      // Low pulls SCL low
);
  typedef enum logic [1:0] {
    WD_WATCH = 2'b00,
    WD_LOW   = 2'b01,
    WD_HIGH  = 2'b10
  } wd_state_e;

  wd_state_e               state_q;     // Watch or recovery phase
  logic [WD_CNT_W-1:0]     idle_q;      // Cycles with no bus activity
  logic [WD_CNT_W-1:0]     half_q;      // Recovery half-period counter
  logic [3:0]              pulses_q;    // SCL pulses issued
  logic                    scl_prev_q;  // Last SCL sample
  logic                    sda_prev_q;  // Last SDA sample
  logic                    expired_q;   // Timeout already acted on
  logic                    activity;    // Any edge on either line
  logic [WD_CNT_W-1:0]     limit;       // Active timeout

  assign activity = (scl_i != scl_prev_q) || (sda_i != sda_prev_q);
  assign limit = wd_fast_i ? WD_CNT_W'(FAST_CYC - 1) : WD_CNT_W'(SLOW_CYC - 1); // [RL6]

  // Edge history of both lines
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_i;
      sda_prev_q <= sda_i;
    end
  end

  // Idle timer and recovery sequencer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q      <= WD_WATCH;
      idle_q       <= '0;
      half_q       <= '0;
      pulses_q     <= 4'h0;
      expired_q    <= 1'b0;
      bus_free_o   <= 1'b0;
      scl_oe_n_o   <= 1'b1;
      recovering_o <= 1'b0;
    end else begin
      bus_free_o <= 1'b0;
      unique case (state_q)
        WD_WATCH: begin
          scl_oe_n_o   <= 1'b1;
          recovering_o <= 1'b0;
          if (wd_disable_i || activity) begin // [RL7]
            // Disabled timer stays cleared so re-enable starts a full period
            idle_q    <= '0;
            expired_q <= 1'b0;
          end else if (idle_q != limit) begin
            idle_q <= idle_q + 1'b1;
          end else if (!expired_q) begin
            expired_q <= 1'b1;
            if (sda_i) begin
              bus_free_o <= 1'b1; // [RL8]
            end else begin
              // Hung bus: start nine SCL clocks
              state_q      <= WD_LOW; // [RL9]
              half_q       <= '0;
              pulses_q     <= 4'h0;
              scl_oe_n_o   <= 1'b0;
              recovering_o <= 1'b1;
            end
          end
        end
        WD_LOW: begin
          if (half_q == WD_CNT_W'(HALF_CYC - 1)) begin
            half_q     <= '0;
            scl_oe_n_o <= 1'b1;
            pulses_q   <= pulses_q + 4'h1;
            state_q    <= WD_HIGH;
          end else begin
            half_q <= half_q + 1'b1;
          end
        end
        WD_HIGH: begin
          if (half_q != WD_CNT_W'(HALF_CYC - 1)) begin
            half_q <= half_q + 1'b1;
          end else if (pulses_q == 4'(RECOV_PULSES)) begin // [RL9]
            // Own edges are not bus activity; restart watch afresh
            state_q      <= WD_WATCH;
            idle_q       <= '0;
            expired_q    <= 1'b0;
            recovering_o <= 1'b0;
          end else begin
            half_q     <= '0;
            scl_oe_n_o <= 1'b0;
            state_q    <= WD_LOW;
          end
        end
        default: state_q <= WD_WATCH;
      endcase
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  wd_off_a: assert property (wd_disable_i && state_q == WD_WATCH |=> !bus_free_o && !recovering_o) // [RL7]
    else $error("Watchdog acted while disabled");
  wd_nine_a: assert property ($fell(recovering_o) |-> pulses_q == 4'(RECOV_PULSES)) // [RL9]
    else $error("Recovery ended without nine clocks");
  wd_recover_c: cover property ($fell(recovering_o));
  wd_free_c: cover property (bus_free_o);
endmodule // i2c_bus_watchdog
`default_nettype wire
